// ### hdl/ulcs_phy_cmd.v
// Purpose: Device-side command decoder, status byte sender and supply control.
// Assumes: Link drives data synchronous to clk; register file lives elsewhere.
// Notes:   Status bytes are sent by turning the bus around with DIR.
`include "ulcs_map.vh"
`default_nettype none
module ulcs_phy_cmd #(
	parameter FIFO_DEPTH = `ULCS_FIFO_DEPTH
) (
	input  wire       clk,
	input  wire       resetn,
	input  wire [7:0] data_in,
	output reg  [7:0] data_out,
	output reg        data_oe,
	output reg        dir,
	output wire       nxt,
	input  wire       stp,
	input  wire       charge_pump_drive,
	input  wire       external_supply_drive,
	input  wire       use_external_indicator,
	input  wire       indicator_passthrough,
	input  wire       bvalid_rise_en,
	input  wire       bvalid_fall_en,
	input  wire       fault_in,
	input  wire [1:0] line_state,
	input  wire       sess_end,
	input  wire       sess_vld,
	input  wire       host_vbus_vld,
	input  wire       bvalid,
	input  wire       rx_active,
	input  wire       rx_error,
	input  wire       host_disconnect,
	input  wire       id_pin,
	input  wire       low_power_exit,
	output wire       charge_pump_en,
	output wire       supply_switch_out_n,
	output wire       supply_switch_oe,
	output reg  [1:0] cmd_kind,
	output reg        cmd_strobe,
	output reg  [7:0] reg_addr,
	output reg        addr_valid,
	output reg        tx_nopid,
	output reg  [3:0] tx_pid,
	output wire       tx_valid,
	input  wire       tx_ready,
	output wire [7:0] tx_data
);
	localparam ST_IDLE  = 3'h0;
	localparam ST_ADDR  = 3'h1;
	localparam ST_DATA  = 3'h2;
	localparam ST_TURN1 = 3'h3;
	localparam ST_STAT  = 3'h4;
	localparam ST_TURN0 = 3'h5;

	reg  [2:0] st_r;
	reg  [7:0] sent_r;
	reg        bvalid_r;
	reg        alt_r;
	reg        pend_r;
	wire [1:0] vb_code;
	wire [1:0] ev_code;
	wire [7:0] stat_now;
	wire       alt_evt;
	wire       changed;
	wire       fifo_in_ready;
	reg        accept;

	// ------------------------------------------------------------
	// Supply control.
	// ------------------------------------------------------------
	assign charge_pump_en      = charge_pump_drive && !external_supply_drive; // RL1 RL3
	assign supply_switch_out_n = 1'b0;
	assign supply_switch_oe    = external_supply_drive; // RL2 RL3

	// ------------------------------------------------------------
	// Status byte fields.
	// ------------------------------------------------------------
	function [1:0] ulcs_vb_enc;
		input hv;
		input sv;
		input se;
		begin
			if (hv) begin
				ulcs_vb_enc = `ULCS_VB_HOST;
			end else if (sv) begin
				ulcs_vb_enc = `ULCS_VB_SESS;
			end else if (se) begin
				ulcs_vb_enc = `ULCS_VB_END;
			end else begin
				ulcs_vb_enc = `ULCS_VB_LOW;
			end
		end
	endfunction

	// Fault level replaces the comparator when both monitoring bits are set.
	assign vb_code = ulcs_vb_enc((use_external_indicator && indicator_passthrough) ? fault_in
		: host_vbus_vld, sess_vld, sess_end); // RL5 RL21

	assign ev_code = host_disconnect ? `ULCS_EV_DISC :
		(rx_active && rx_error) ? `ULCS_EV_ERROR :
		rx_active ? `ULCS_EV_ACTIVE : `ULCS_EV_NONE; // RL22

	// Line state is passed through as the analog front end encodes it.
	assign stat_now = {alt_r, id_pin, ev_code, vb_code, line_state}; // RL16 RL19 RL20

	assign alt_evt = (bvalid && !bvalid_r && bvalid_rise_en) ||
		(!bvalid && bvalid_r && bvalid_fall_en); // RL17

	assign changed = (stat_now[6:0] != sent_r[6:0]) || alt_evt; // RL13 RL18 RL5

	// ------------------------------------------------------------
	// Link bus state machine.
	// ------------------------------------------------------------
	assign nxt = accept && !dir; // RL23

	ulcs_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH),
		.AW    (3)
	) u_fifo (
		.clk       (clk),
		.resetn    (resetn),
		.in_valid  (accept && st_r == ST_DATA),
		.in_ready  (fifo_in_ready),
		.in_data   (data_in),
		.out_valid (tx_valid),
		.out_ready (tx_ready),
		.out_data  (tx_data)
	);

	always @* begin
		case (st_r)
			ST_IDLE: accept = (data_in != 8'h00) && !pend_r && !changed; // RL6 RL7
			ST_ADDR: accept = 1'b1; // RL11
			ST_DATA: accept = fifo_in_ready && !stp;
			default: accept = 1'b0;
		endcase
	end

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_r       <= ST_IDLE;
			sent_r     <= 8'h00;
			bvalid_r   <= 1'b0;
			alt_r      <= 1'b0;
			pend_r     <= 1'b0;
			dir        <= 1'b0;
			data_out   <= 8'h00;
			data_oe    <= 1'b0;
			cmd_kind   <= `ULCS_CODE_IDLE;
			cmd_strobe <= 1'b0;
			reg_addr   <= 8'h00;
			addr_valid <= 1'b0;
			tx_nopid   <= 1'b0;
			tx_pid     <= 4'h0;
		end else begin
			bvalid_r   <= bvalid;
			cmd_strobe <= 1'b0;
			addr_valid <= 1'b0;
			if (alt_evt) begin
				alt_r <= 1'b1;
			end
			// A change that the low-power exit has already undone is dropped.
			if (changed && !(low_power_exit && !alt_evt)) begin // RL15
				pend_r <= 1'b1;
			end
			case (st_r)
				ST_IDLE: begin
					if (pend_r || changed) begin
						st_r <= ST_TURN1;
						dir  <= 1'b1; // RL13
					end else if (accept) begin
						cmd_kind   <= data_in[7:6]; // RL8
						cmd_strobe <= 1'b1;
						tx_pid     <= data_in[3:0]; // RL10
						tx_nopid   <= (data_in[7:6] == `ULCS_CODE_TX) &&
							(data_in[5:0] == 6'h00); // RL9
						if (data_in[7:6] != `ULCS_CODE_TX &&
							data_in[5:0] == `ULCS_EXT_PAYLOAD) begin
							st_r <= ST_ADDR; // RL11
						end else begin
							reg_addr   <= {2'h0, data_in[5:0]}; // RL12
							addr_valid <= (data_in[7:6] != `ULCS_CODE_TX);
							st_r       <= ST_DATA;
						end
					end
				end
				ST_ADDR: begin
					reg_addr   <= data_in; // RL11
					addr_valid <= 1'b1;
					st_r       <= ST_DATA;
				end
				ST_DATA: begin
					// Bytes after acceptance, NOPID data included, enter the FIFO.
					if (stp) begin // RL9
						st_r <= ST_IDLE;
					end
				end
				ST_TURN1: begin
					data_out <= stat_now; // RL24
					data_oe  <= 1'b1;
					sent_r   <= stat_now;
					st_r     <= ST_STAT;
				end
				ST_STAT: begin
					if (changed) begin
						data_out <= stat_now; // RL14
						sent_r   <= stat_now;
					end else begin
						data_oe <= 1'b0;
						dir     <= 1'b0;
						alt_r   <= 1'b0;
						pend_r  <= 1'b0;
						st_r    <= ST_TURN0; // RL24
					end
				end
				ST_TURN0: begin
					st_r <= ST_IDLE;
				end
				default: begin
					st_r <= ST_IDLE;
				end
			endcase
		end
	end
	// RL25: single clock throughout.
endmodule
`default_nettype wire

// ### include/ulcs_map.vh
// Purpose: Constants for the link-side command decoder and status byte generator.
// Assumes: One 60 MHz interface clock; all inputs except the asynchronous resetn synchronous to it.
// Notes:   Constants are macros; the file is guarded against double inclusion.
//
// Contract
// RL1: Charge pump enabled when pump bit set and external supply bit clear.
// RL2: External supply bit set pulls the open-drain switch output low.
// RL3: Both drive bits clear disable internal and external supplies.
// RL4: Link sets external indicator and passthrough bits to watch the fault input.
// RL5: With monitoring on, fault level becomes host valid; every change sends status.
// RL6: Idle bus value 00h is a no-operation command.
// RL7: Nonzero command accepted with NXT; link then supplies the data bytes.
// RL8: Top two command bits: idle, transmit, register write, register read.
// RL9: Transmit with zero payload sends without identifier after next byte accepted.
// RL10: Transmit with nonzero low nibble uses it as packet identifier.
// RL11: Payload 10 1111b selects extended addressing; an 8-bit address follows.
// RL12: Other register payloads are the six-bit immediate address.
// RL13: Status is sent with DIR high whenever any field changes.
// RL14: Link accepts status bytes at any moment, including back to back.
// RL15: Status may be skipped on low-power exit if the cause vanished.
// RL16: Status byte: line state 1:0, bus state 3:2, event 5:4, ID bit 6.
// RL17: Enabled session-valid rise or fall sends status with bit 7 set; for an edge seen in ST_TURN1 or ST_STAT the code sends status without bit 7.
// RL18: Any change on a data line sends updated line state.
// RL19: Peripheral line state encodings per speed mode are passed through.
// RL20: Host line state encodings per speed mode are passed through.
// RL21: Bus state: 00 below end, 01 between, 10 session valid, 11 host valid.
// RL22: Event: 00 none, 01 active, 11 active with error, 10 disconnect.
// RL23: While DIR is high, NXT is low and status is driven.
// RL24: One turnaround cycle with nobody driving whenever DIR changes.
// RL25: Everything is synchronous to the single interface clock; the code resets asynchronously on resetn.
`ifndef ULCS_MAP_VH
`define ULCS_MAP_VH
`define ULCS_CODE_IDLE   2'h0
`define ULCS_CODE_TX     2'h1
`define ULCS_CODE_REGW   2'h2
`define ULCS_CODE_REGR   2'h3
`define ULCS_EXT_PAYLOAD 6'h2F
`define ULCS_VB_END      2'h0
`define ULCS_VB_LOW      2'h1
`define ULCS_VB_SESS     2'h2
`define ULCS_VB_HOST     2'h3
`define ULCS_EV_NONE     2'h0
`define ULCS_EV_ACTIVE   2'h1
`define ULCS_EV_DISC     2'h2
`define ULCS_EV_ERROR    2'h3
`define ULCS_FIFO_DEPTH  8
`endif

// ### hdl/ulcs_fifo.v
// Purpose: Small synchronous FIFO for the transmit data path.
// Assumes: Single clock, asynchronous active-low reset.
// Notes:   Full and empty are exact; pointers carry one extra wrap bit.
`default_nettype none
module ulcs_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 8,
	parameter AW    = 3
) (
	input  wire             clk,
	input  wire             resetn,
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	output wire             out_valid,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW:0]      wp_r;
	reg [AW:0]      rp_r;
	wire            empty;
	wire            full;

	assign empty     = (wp_r == rp_r);
	assign full      = (wp_r[AW-1:0] == rp_r[AW-1:0]) && (wp_r[AW] != rp_r[AW]);
	assign in_ready  = !full;
	assign out_valid = !empty;
	assign out_data  = mem[rp_r[AW-1:0]];

	always @(posedge clk) begin
		if (in_valid && !full) begin
			mem[wp_r[AW-1:0]] <= in_data;
		end
	end

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wp_r <= {(AW+1){1'b0}};
			rp_r <= {(AW+1){1'b0}};
		end else begin
			if (in_valid && !full) begin
				wp_r <= wp_r + 1'b1;
			end
			if (out_ready && !empty) begin
				rp_r <= rp_r + 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ### dv/ulcs_props_properties.sv
// Purpose: Port assertions for the command and status block.
// Assumes: One clock; resetn is asynchronous, active low.
// Notes:   Bound to the design after the module.
`default_nettype none
module ulcs_props (
	input wire logic       clk,
	input wire logic       resetn,
	input wire logic [7:0] data_in,
	input wire logic       data_oe,
	input wire logic       dir,
	input wire logic       nxt,
	input wire logic       charge_pump_drive,
	input wire logic       external_supply_drive,
	input wire logic       charge_pump_en,
	input wire logic       supply_switch_out_n,
	input wire logic       supply_switch_oe,
	input wire logic [1:0] cmd_kind,
	input wire logic       cmd_strobe,
	input wire logic [7:0] reg_addr,
	input wire logic       addr_valid,
	input wire logic       tx_nopid,
	input wire logic [3:0] tx_pid,
	input wire logic [1:0] line_state
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	a_pump_on: assert property (
		charge_pump_en == (charge_pump_drive && !external_supply_drive)) else $error("pump");
	a_switch_low: assert property (
		external_supply_drive |-> supply_switch_oe && !supply_switch_out_n) else $error("switch");
	a_nxt_quiet: assert property (dir |-> !nxt) else $error("nxt with dir");
	a_turn_gap: assert property ($changed(dir) |-> !data_oe) else $error("no gap");
	a_cmd_kind: assert property (
		cmd_strobe |-> $past(nxt) && cmd_kind == $past(data_in[7:6])) else $error("kind");
	a_pid_field: assert property (
		cmd_strobe && cmd_kind == 2'h1 && $past(data_in[3:0]) != 4'h0
		|-> tx_pid == $past(data_in[3:0]) && !tx_nopid) else $error("pid");
	a_nopid_flag: assert property (
		cmd_strobe && cmd_kind == 2'h1 && $past(data_in[5:0]) == 6'h00
		|-> tx_nopid) else $error("nopid");
	a_imm_addr: assert property (
		cmd_strobe && cmd_kind[1] && $past(data_in[5:0]) != 6'h2F
		|-> reg_addr == {2'h0, $past(data_in[5:0])}) else $error("addr");
	a_addr_taken: assert property (
		addr_valid |-> $past(nxt) && !$past(dir)) else $error("addr without accept");
	a_line_report: assert property (
		$changed(line_state) |-> ##[1:20] dir) else $error("no status");
endmodule
bind ulcs_phy_cmd ulcs_props chk (.*);
`default_nettype wire

// ### dv/ulcs_link_model.sv
// Purpose: Link side of the command bus.
// Assumes: The bus reads back inverted while the device owns it.
// Notes:   Every wait for the accept strobe is bounded.
`default_nettype none
module ulcs_link_model (
	input  wire logic       clk,
	input  wire logic       dir,
	input  wire logic       nxt,
	output wire logic [7:0] data_in,
	output var  logic       stp
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] drv = 8'h00;
	initial stp = 1'b0;
	assign data_in = dir ? ~drv : drv;
	task automatic xfer(input logic [7:0] cmd, input int n, output bit ok);
		int j;
		int t;
		ok = 1;
		@(posedge clk);
		for (j = 0; j <= n && ok; j++) begin
			drv <= (j == 0) ? cmd : 8'h59 + j[7:0];
			t = 0;
			do begin
				@(posedge clk);
				t++;
			end while (!nxt && t < 20);
			ok = nxt;
		end
		drv <= 8'h00;
		stp <= 1'b1;
		@(posedge clk);
		stp <= 1'b0;
		#1;
	endtask
endmodule
`default_nettype wire

// ### dv/tb_ulpi_phy_command_status.sv
// Purpose: Self-checking bench for the command and status block.
// Assumes: The link model drives the command bus; the bench drives the rest.
// Notes:   Status rows first, then supply, fault, alert, commands, FIFO, reset.
`default_nettype none
module tb_ulpi_phy_command_status;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, resetn = 0, tx_ready = 1, bvalid = 0, fault_in = 0, low_power_exit = 0;
	logic charge_pump_drive = 0, external_supply_drive = 0, bvalid_rise_en = 0;
	logic bvalid_fall_en = 0, use_external_indicator = 0, indicator_passthrough = 0;
	logic [8:0] st = 9'h000;
	wire logic id_pin, host_disconnect, rx_error, rx_active, host_vbus_vld, sess_vld, sess_end;
	wire logic [1:0] line_state;
	logic [7:0] data_in, data_out, reg_addr, tx_data;
	logic [3:0] tx_pid;
	logic [1:0] cmd_kind;
	logic data_oe, dir, nxt, stp, charge_pump_en, supply_switch_out_n, supply_switch_oe;
	logic cmd_strobe, addr_valid, tx_nopid, tx_valid;
	int n_errors = 0, checks_done = 0, i, k;
	bit ok;
	logic [16:0] rows [5] = '{17'h10541, 17'h02216, 17'h06B3B, 17'h1906C, 17'h00D09};
	assign {id_pin, host_disconnect, rx_error, rx_active, host_vbus_vld, sess_vld, sess_end,
		line_state} = st;
	always #10 clk = ~clk;
	ulcs_phy_cmd uut (.*);
	ulcs_link_model link (.clk, .dir, .nxt, .data_in, .stp);
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic results;
		$display("errors=%0d checks=%0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic await(input logic [7:0] exp);
		k = 0;
		do begin
			@(posedge clk);
			#1;
			k++;
		end while (k < 40 && !(data_oe && data_out === exp));
		chk({data_oe, data_out}, {1'b1, exp});
		if (k == 40) results;
	endtask
	initial begin
		repeat (4) @(posedge clk);
		resetn <= 1;
		foreach (rows[r]) begin
			@(posedge clk);
			st <= rows[r][16:8];
			await(rows[r][7:0]);
		end
		for (i = 0; i < 4; i++) begin
			@(posedge clk);
			{charge_pump_drive, external_supply_drive} <= i[1:0];
			@(posedge clk);
			#1;
			chk({supply_switch_oe, supply_switch_out_n, charge_pump_en},
				{i[0], 1'b0, i == 2});
		end
		@(posedge clk);
		{use_external_indicator, indicator_passthrough, fault_in} <= 3'h7;
		await(8'h0D);
		@(posedge clk);
		fault_in <= 0;
		await(8'h09);
		@(posedge clk);
		{bvalid_rise_en, bvalid_fall_en} <= 2'h3;
		@(posedge clk);
		bvalid <= 1;
		await(8'h89);
		@(posedge clk);
		bvalid <= 0;
		await(8'h89);
		link.xfer(8'h43, 2, ok);
		chk({ok, cmd_kind, tx_pid}, 7'h53);
		link.xfer(8'h40, 1, ok);
		chk({ok, cmd_kind, tx_nopid}, 4'hB);
		link.xfer(8'h85, 1, ok);
		chk({ok, cmd_kind, reg_addr}, 11'h605);
		link.xfer(8'hAF, 2, ok);
		chk({ok, cmd_kind, reg_addr}, 11'h65A);
		link.xfer(8'hC7, 0, ok);
		chk({ok, cmd_kind, reg_addr}, 11'h707);
		link.xfer(8'hEF, 1, ok);
		chk({ok, cmd_kind, reg_addr}, 11'h75A);
		@(posedge clk);
		tx_ready <= 0;
		link.xfer(8'h41, 9, ok);
		chk(ok, 0);
		@(posedge clk);
		tx_ready <= 1;
		for (i = 0; i < 8; i++) begin
			#1;
			chk({tx_valid, tx_data}, {1'b1, 8'h5A + i[7:0]});
			@(posedge clk);
		end
		#1;
		chk(tx_valid, 0);
		@(posedge clk);
		resetn <= 0;
		@(posedge clk);
		#1;
		chk({dir, data_oe, cmd_strobe, nxt}, 4'h0);
		@(posedge clk);
		resetn <= 1;
		await(8'h09);
		results;
	end
endmodule
`default_nettype wire
